// >>> iwc_pkg.sv
// constants, register map and state types of the interrupt and wake controller
package iwc_pkg;
    // ----------------------------------------
    // register indices and byte addresses
    // ----------------------------------------
    localparam logic [7:0] IDX_ICF = 8'h0B;
    localparam logic [7:0] IDX_TEC = 8'h81;
    localparam logic [7:0] IDX_IST = 8'h90;
    localparam logic [7:0] IDX_IMK = 8'h91;
    localparam logic [11:0] ADDR_ICF = {2'b00, IDX_ICF, 2'b00};
    localparam logic [11:0] ADDR_TEC = {2'b00, IDX_TEC, 2'b00};
    localparam logic [11:0] ADDR_IST = {2'b00, IDX_IST, 2'b00};
    localparam logic [11:0] ADDR_IMK = {2'b00, IDX_IMK, 2'b00};
    // ----------------------------------------
    // interrupt_control_flags fields
    // ----------------------------------------
    localparam int BIT_GIE = 7;
    localparam int BIT_TOE = 5;
    localparam int BIT_PIE = 4;
    localparam int BIT_PCE = 3;
    localparam int BIT_TOF = 2;
    localparam int BIT_PIF = 1;
    localparam int BIT_PCF = 0;
    localparam logic [7:0] ICF_RESET = 8'h00;
    // ----------------------------------------
    // timer_edge_config fields
    // ----------------------------------------
    localparam int BIT_EDGE_SEL = 6;
    localparam logic [7:0] TEC_RESET = 8'hFF;
    // ----------------------------------------
    // block status and mask bits
    // ----------------------------------------
    localparam int ST_TAKEN = 0;
    localparam int ST_WAKE = 1;
    localparam logic [1:0] IMK_RESET = 2'b00;
    // ----------------------------------------
    // core side constants, timing and axi response codes
    // ----------------------------------------
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    localparam logic [7:0] TIMER_MAX = 8'hFF;
    localparam logic [1:0] DUMMY_CYCLES = 2'd2;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        TK_IDLE,
        TK_DUMMY,
        TK_WAKE_EXEC
    } iwc_take_type;
endpackage

// >>> iwc_top.sv
// interrupt flag, enable, vectoring and wake logic with an axi4-lite register port
//
// Contract
// - three sources: pin edge, timer, port change
// - control register holds flags, enables, global enable
// - bit 7 global enable gates all interrupts
// - every reset clears the global enable
// - flags set regardless of any enable
// - taking irq clears enable, pushes, vectors 0004h
// - return op leaves routine and sets enable
// - pin/change latency three or four cycles
// - enable clear: next cycle nop, irqs stay pending
// - edge select bit 6 picks rising edge
// - selected pin edge sets flag bit 1
// - pin enable bit 4 gates pin irq
// - pin wakes halt only if enabled before
// - after wake run PC+1, then vector
// - wake leaves a control flag changed; wake here changes no icf bit, it only sets ST_WAKE
// - timer max to zero sets bit 2, enable 5
// - port change sets bit 0, own enable
`timescale 1ns/10ps
module iwc_top
    import iwc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic EDGE_IRQ_PIN,
    input wire logic [3:0] CHANGE_SENSE_PINS,
    input wire logic [7:0] TIMER_COUNT,
    input wire logic [12:0] CORE_PC_NEXT,
    input wire logic CORE_RETURN_FROM_IRQ_OP,
    input wire logic CORE_GIE_CLEAR_OP,
    input wire logic CORE_HALT_OP,
    output logic CORE_FORCE_NOP,
    output logic CORE_PUSH,
    output logic [12:0] CORE_PUSH_ADDR,
    output logic CORE_VECTOR_LOAD,
    output logic [12:0] CORE_VECTOR_ADDR,
    output logic CORE_HALTED,
    output logic CORE_WAKE,
    output logic GLOBAL_IRQ_ENABLE,
    output logic IRQ
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] aw_addr;
        logic aw_have;
        logic [7:0] w_data;
        logic w_lane0;
        logic w_have;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [7:0] icf;
        logic [7:0] tec;
        logic [1:0] ist;
        logic [1:0] imk;
        logic irq;
        logic pin_prev;
        logic [3:0] chg_prev;
        logic [7:0] tmr_prev;
        logic primed;
        logic halted;
        logic [2:0] sleep_en;
        iwc_take_type tk;
        logic [1:0] tk_cnt;
        logic suppress;
        logic nop;
        logic push;
        logic [12:0] push_addr;
        logic vload;
        logic [12:0] vaddr;
        logic wake;
    } iwc_state_type;

    iwc_state_type s_q;
    iwc_state_type s_d;

    logic pin_evt;
    logic tmr_evt;
    logic chg_evt;
    logic [2:0] flags;
    logic [2:0] ens;
    logic pending;
    logic wr_fire;
    logic rd_fire;
    logic [ADDR_W-1:0] rd_addr;

    always_comb begin
        s_d = s_q;
        s_d.push = 1'b0;
        s_d.vload = 1'b0;
        s_d.wake = 1'b0;
        s_d.suppress = 1'b0;
        rd_addr = S_AXI_ARADDR;

        // ----------------------------------------
        // source event detection
        // ----------------------------------------
        s_d.pin_prev = EDGE_IRQ_PIN;
        s_d.chg_prev = CHANGE_SENSE_PINS;
        s_d.tmr_prev = TIMER_COUNT;
        // first edge after reset only loads the samples, so pins away from zero fake no event
        s_d.primed = 1'b1;
        if (s_q.tec[BIT_EDGE_SEL]) begin
            pin_evt = s_q.primed & EDGE_IRQ_PIN & ~s_q.pin_prev;
        end else begin
            pin_evt = s_q.primed & ~EDGE_IRQ_PIN & s_q.pin_prev;
        end
        tmr_evt = s_q.primed && (s_q.tmr_prev == TIMER_MAX) && (TIMER_COUNT == 8'h00);
        chg_evt = s_q.primed && (CHANGE_SENSE_PINS != s_q.chg_prev);

        // ----------------------------------------
        // axi write channel
        // ----------------------------------------
        if (S_AXI_AWVALID && s_q.awready) begin
            s_d.aw_addr = S_AXI_AWADDR;
            s_d.aw_have = 1'b1;
        end
        if (S_AXI_WVALID && s_q.wready) begin
            s_d.w_data = S_AXI_WDATA[7:0];
            s_d.w_lane0 = S_AXI_WSTRB[0];
            s_d.w_have = 1'b1;
        end
        if (s_q.bvalid && S_AXI_BREADY) begin
            s_d.bvalid = 1'b0;
        end
        wr_fire = s_q.aw_have && s_q.w_have && !s_q.bvalid;
        if (wr_fire) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            case (s_q.aw_addr)
                ADDR_ICF: begin
                    // a written zero clears a flag; a set in the same cycle wins below
                    if (s_q.w_lane0) begin
                        s_d.icf = s_q.w_data;
                    end
                end
                ADDR_TEC: begin
                    if (s_q.w_lane0) begin
                        s_d.tec = s_q.w_data;
                    end
                end
                ADDR_IMK: begin
                    if (s_q.w_lane0) begin
                        s_d.imk = s_q.w_data[1:0];
                    end
                end
                ADDR_IST: begin
                end
                default: begin
                    s_d.bresp = RESP_SLVERR;
                end
            endcase
        end

        // ----------------------------------------
        // axi read channel
        // ----------------------------------------
        if (s_q.rvalid && S_AXI_RREADY) begin
            s_d.rvalid = 1'b0;
        end
        rd_fire = S_AXI_ARVALID && s_q.arready;
        if (rd_fire) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = RESP_OKAY;
            case (rd_addr)
                ADDR_ICF: begin
                    s_d.rdata = s_q.icf;
                end
                ADDR_TEC: begin
                    s_d.rdata = s_q.tec;
                end
                ADDR_IST: begin
                    s_d.rdata = {6'h00, s_q.ist};
                    s_d.ist = 2'b00;
                end
                ADDR_IMK: begin
                    s_d.rdata = {6'h00, s_q.imk};
                end
                default: begin
                    s_d.rdata = 8'h00;
                    s_d.rresp = RESP_SLVERR;
                end
            endcase
        end

        // ----------------------------------------
        // flags: hardware set wins over a write
        // ----------------------------------------
        if (pin_evt) begin
            s_d.icf[BIT_PIF] = 1'b1;
        end
        if (tmr_evt) begin
            s_d.icf[BIT_TOF] = 1'b1;
        end
        if (chg_evt) begin
            s_d.icf[BIT_PCF] = 1'b1;
        end

        // ----------------------------------------
        // global enable from the core
        // ----------------------------------------
        if (CORE_RETURN_FROM_IRQ_OP) begin
            s_d.icf[BIT_GIE] = 1'b1;
        end
        if (CORE_GIE_CLEAR_OP) begin
            s_d.icf[BIT_GIE] = 1'b0;
            s_d.suppress = 1'b1;
        end

        // registered flags and enables, so a new event needs one edge to count
        flags = {s_q.icf[BIT_TOF], s_q.icf[BIT_PIF], s_q.icf[BIT_PCF]};
        ens = {s_q.icf[BIT_TOE], s_q.icf[BIT_PIE], s_q.icf[BIT_PCE]};
        pending = |(flags & ens);

        // ----------------------------------------
        // halt and wake
        // ----------------------------------------
        if (CORE_HALT_OP && !s_q.halted) begin
            s_d.halted = 1'b1;
            s_d.sleep_en = ens;
        end
        if (s_q.halted && |(flags & s_q.sleep_en)) begin
            // the flag that woke the core stays set for software to see
            s_d.halted = 1'b0;
            s_d.wake = 1'b1;
            s_d.ist[ST_WAKE] = 1'b1;
            s_d.tk = TK_WAKE_EXEC;
        end

        // ----------------------------------------
        // vectoring sequence
        // ----------------------------------------
        case (s_q.tk)
            TK_IDLE: begin
                // suppress blocks the take but leaves the flags pending
                if (pending && s_q.icf[BIT_GIE] && !s_q.suppress && !s_q.halted) begin
                    s_d.tk = TK_DUMMY;
                    s_d.tk_cnt = DUMMY_CYCLES - 2'd1;
                    s_d.push_addr = CORE_PC_NEXT;
                end
            end
            TK_DUMMY: begin
                // fixed dummy count keeps latency independent of instruction length
                if (s_q.tk_cnt == 2'd0) begin
                    s_d.tk = TK_IDLE;
                    s_d.icf[BIT_GIE] = 1'b0;
                    s_d.push = 1'b1;
                    s_d.vload = 1'b1;
                    s_d.vaddr = IRQ_VECTOR;
                    s_d.ist[ST_TAKEN] = 1'b1;
                end else begin
                    s_d.tk_cnt = s_q.tk_cnt - 2'd1;
                end
            end
            TK_WAKE_EXEC: begin
                // one cycle for the instruction after the halt, then normal arbitration
                s_d.tk = TK_IDLE;
            end
            default: begin
                s_d.tk = TK_IDLE;
            end
        endcase

        s_d.nop = (s_d.tk == TK_DUMMY) || s_d.suppress;
        s_d.awready = !s_d.aw_have && !s_d.bvalid;
        s_d.wready = !s_d.w_have && !s_d.bvalid;
        s_d.arready = !s_d.rvalid;
        s_d.irq = |(s_d.ist & s_d.imk);
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            s_q <= '0;
            s_q.icf <= ICF_RESET;
            s_q.tec <= TEC_RESET;
            s_q.imk <= IMK_RESET;
            s_q.tk <= TK_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign S_AXI_AWREADY = s_q.awready;
    assign S_AXI_WREADY = s_q.wready;
    assign S_AXI_BVALID = s_q.bvalid;
    assign S_AXI_BRESP = s_q.bresp;
    assign S_AXI_ARREADY = s_q.arready;
    assign S_AXI_RVALID = s_q.rvalid;
    assign S_AXI_RDATA = {24'h00_0000, s_q.rdata};
    assign S_AXI_RRESP = s_q.rresp;
    assign CORE_FORCE_NOP = s_q.nop;
    assign CORE_PUSH = s_q.push;
    assign CORE_PUSH_ADDR = s_q.push_addr;
    assign CORE_VECTOR_LOAD = s_q.vload;
    assign CORE_VECTOR_ADDR = s_q.vaddr;
    assign CORE_HALTED = s_q.halted;
    assign CORE_WAKE = s_q.wake;
    assign GLOBAL_IRQ_ENABLE = s_q.icf[BIT_GIE];
    assign IRQ = s_q.irq;
endmodule // iwc_top

// >>> iwc_monitor.sv
// assertions on the core-side outputs of the interrupt and wake controller
`timescale 1ns/10ps
module iwc_monitor (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CORE_GIE_CLEAR_OP,
    input wire logic CORE_RETURN_FROM_IRQ_OP,
    input wire logic CORE_FORCE_NOP,
    input wire logic CORE_PUSH,
    input wire logic CORE_VECTOR_LOAD,
    input wire logic [12:0] CORE_VECTOR_ADDR,
    input wire logic CORE_HALTED,
    input wire logic CORE_WAKE,
    input wire logic GLOBAL_IRQ_ENABLE
);
    // ----------------------------------------
    // take steps
    // ----------------------------------------
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);
    sequence s_dummy;
        CORE_FORCE_NOP [*2];
    endsequence
    sequence s_vec;
        CORE_PUSH && CORE_VECTOR_LOAD && CORE_VECTOR_ADDR == 13'h0004;
    endsequence
    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_take_steps: assert property (
        $rose(CORE_FORCE_NOP) && GLOBAL_IRQ_ENABLE |-> s_dummy ##1 s_vec)
        else $error("take sequence wrong");
    chk_push_vec: assert property (
        CORE_PUSH |-> CORE_VECTOR_LOAD && !GLOBAL_IRQ_ENABLE ##1 !CORE_PUSH)
        else $error("push without vector load");
    chk_take_gie: assert property (
        CORE_VECTOR_LOAD |-> $past(GLOBAL_IRQ_ENABLE))
        else $error("take while disabled");
    chk_clr_nop: assert property (
        CORE_GIE_CLEAR_OP |=> !GLOBAL_IRQ_ENABLE ##[0:1] CORE_FORCE_NOP)
        else $error("no nop after enable clear");
    chk_ret_gie: assert property (
        CORE_RETURN_FROM_IRQ_OP && !CORE_GIE_CLEAR_OP |=> GLOBAL_IRQ_ENABLE)
        else $error("return did not enable");
    chk_wake_exit: assert property (
        CORE_WAKE |-> !CORE_HALTED && $past(CORE_HALTED))
        else $error("wake outside halt");
    chk_wake_vec: assert property (
        CORE_WAKE && GLOBAL_IRQ_ENABLE |-> ##[2:5] s_vec)
        else $error("no vector after wake");
    chk_gie_reset: assert property (
        $fell(RST) |-> !GLOBAL_IRQ_ENABLE)
        else $error("enable set after reset");
endmodule // iwc_monitor
bind iwc_top iwc_monitor iwc_monitor_inst (
    .MCLK(MCLK), .RST(RST), .CORE_GIE_CLEAR_OP(CORE_GIE_CLEAR_OP),
    .CORE_RETURN_FROM_IRQ_OP(CORE_RETURN_FROM_IRQ_OP), .CORE_FORCE_NOP(CORE_FORCE_NOP),
    .CORE_PUSH(CORE_PUSH), .CORE_VECTOR_LOAD(CORE_VECTOR_LOAD),
    .CORE_VECTOR_ADDR(CORE_VECTOR_ADDR), .CORE_HALTED(CORE_HALTED),
    .CORE_WAKE(CORE_WAKE), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE));

// >>> iwc_core_model.sv
// core model: program counter, one-deep return stack, op pulses
`timescale 1ns/10ps
module iwc_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic force_nop,
    input wire logic push,
    input wire logic [12:0] push_addr,
    input wire logic vector_load,
    input wire logic [12:0] vector_addr,
    input wire logic halted,
    input wire logic ret_cmd,
    input wire logic clr_cmd,
    input wire logic halt_cmd,
    output logic [12:0] pc_next,
    output logic ret_op,
    output logic clr_op,
    output logic halt_op
);
    logic [12:0] pc_q;
    logic [12:0] stack_q;
    assign pc_next = pc_q + 13'h0001;
    // one stack level only: nested takes are not exercised
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc_q <= '0;
            stack_q <= '0;
            ret_op <= 1'b0;
            clr_op <= 1'b0;
            halt_op <= 1'b0;
        end else begin
            ret_op <= ret_cmd;
            clr_op <= clr_cmd;
            halt_op <= halt_cmd;
            if (push) begin
                stack_q <= push_addr;
            end
            if (vector_load) begin
                pc_q <= vector_addr;
            end else if (ret_op) begin
                pc_q <= stack_q;
            end else if (!force_nop && !halted) begin
                pc_q <= pc_next;
            end
        end
    end
endmodule // iwc_core_model

// >>> tb_irq_wake_controller.sv
// self-checking bench of the interrupt and wake controller
`timescale 1ns/10ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
    $display("[ERR] %0t value differs", $time); end end
`define WAITF(s) \
    for (n = 0; n < 60 && !(s); n++) \
        @(posedge mclk); \
    if (!(s)) begin \
        n_fail++; \
        summarize(); \
    end
module tb_irq_wake_controller
    import iwc_pkg::*;
;
    logic mclk = 1'b0, rst = 1'b1, pin = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic ret_cmd = 1'b0, clr_cmd = 1'b0, halt_cmd = 1'b0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] chg = 4'h0;
    logic [7:0] tmr = 8'h00, x;
    logic awready, wready, bvalid, arready, rvalid, push, vload, fnop, halted, wake, global_irq_enable, irq;
    logic ret_op, clr_op, halt_op;
    logic [1:0] bresp, rresp, r;
    logic [12:0] pc_next, push_addr, vaddr, pc_exp;
    int n_fail = 0, samples_checked = 0, n;
    logic [11:0] ra[4] = '{ADDR_TEC, ADDR_ICF, ADDR_IMK, 12'h100};
    logic [7:0] rw[4] = '{8'h40, 8'h78, 8'h03, 8'h55};
    logic [7:0] rx[4] = '{8'h40, 8'h78, 8'h03, 8'h00};
    logic [1:0] rr[4] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_SLVERR};

    iwc_top iwc_top_inst (.MCLK(mclk), .RST(rst), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .EDGE_IRQ_PIN(pin), .CHANGE_SENSE_PINS(chg),
        .TIMER_COUNT(tmr), .CORE_PC_NEXT(pc_next), .CORE_RETURN_FROM_IRQ_OP(ret_op),
        .CORE_GIE_CLEAR_OP(clr_op), .CORE_HALT_OP(halt_op), .CORE_FORCE_NOP(fnop),
        .CORE_PUSH(push), .CORE_PUSH_ADDR(push_addr), .CORE_VECTOR_LOAD(vload),
        .CORE_VECTOR_ADDR(vaddr), .CORE_HALTED(halted), .CORE_WAKE(wake),
        .GLOBAL_IRQ_ENABLE(global_irq_enable), .IRQ(irq));
    iwc_core_model iwc_core_model_inst (.clk(mclk), .rst(rst), .force_nop(fnop),
        .push(push), .push_addr(push_addr), .vector_load(vload), .vector_addr(vaddr),
        .halted(halted), .ret_cmd(ret_cmd), .clr_cmd(clr_cmd), .halt_cmd(halt_cmd),
        .pc_next(pc_next), .ret_op(ret_op), .clr_op(clr_op), .halt_op(halt_op));

    // ----------------------------------------
    // bus and helper tasks
    // ----------------------------------------
    task summarize();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] rs);
        int i;
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 40 && !bvalid; i++) begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        rs = bresp;
        bready <= 1'b0;
        if (i == 40) begin
            n_fail++;
            summarize();
        end
        @(posedge mclk);
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] rs);
        int i;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 40 && !rvalid; i++) begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end
        d = rdata[7:0];
        rs = rresp;
        rready <= 1'b0;
        if (i == 40) begin
            n_fail++;
            summarize();
        end
        @(posedge mclk);
    endtask
    // one-cycle command to the core model (0 return, 1 enable clear, 2 halt),
    // then let the op reach the block
    task automatic tick(input int c);
        ret_cmd <= (c == 0);
        clr_cmd <= (c == 1);
        halt_cmd <= (c == 2);
        @(posedge mclk);
        ret_cmd <= 1'b0;
        clr_cmd <= 1'b0;
        halt_cmd <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        forever #20 mclk = ~mclk;
    end
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        `CHK(global_irq_enable, 1'b0)
        rd(ADDR_ICF, x, r);
        `CHK(x, ICF_RESET)
        rd(ADDR_TEC, x, r);
        `CHK(x, TEC_RESET)
        for (int k = 0; k < 4; k++) begin
            wr(ra[k], rw[k], r);
            `CHK(r, rr[k])
            rd(ra[k], x, r);
            `CHK(x, rx[k])
            `CHK(r, rr[k])
        end
        $display("register rows done");
        tmr <= TIMER_MAX;
        chg <= 4'h5;
        @(posedge mclk);
        tmr <= 8'h00;
        repeat (3) @(posedge mclk);
        rd(ADDR_ICF, x, r);
        `CHK(x, 8'h7D)
        wr(ADDR_ICF, 8'h90, r);
        pin <= 1'b1;
        repeat (2) @(posedge mclk);
        // the return address is what the core would run next as the take begins
        pc_exp = pc_next;
        `WAITF(vload)
        // two edges sample the pin and start the take, three more bring the vector
        `CHK(n, 3)
        `CHK(push_addr, pc_exp)
        `CHK(vaddr, IRQ_VECTOR)
        `CHK(global_irq_enable, 1'b0)
        repeat (2) @(posedge mclk);
        `CHK(irq, 1'b1)
        wr(ADDR_IMK, 8'h00, r);
        repeat (2) @(posedge mclk);
        `CHK(irq, 1'b0)
        wr(ADDR_IMK, 8'h01, r);
        rd(ADDR_IST, x, r);
        `CHK(x[0], 1'b1)
        repeat (2) @(posedge mclk);
        `CHK(irq, 1'b0)
        $display("take test done");
        wr(ADDR_ICF, 8'h00, r);
        wr(ADDR_TEC, 8'h00, r);
        pin <= 1'b0;
        repeat (3) @(posedge mclk);
        rd(ADDR_ICF, x, r);
        `CHK(x, 8'h02)
        wr(ADDR_ICF, 8'h80, r);
        // the rising edge lands after the write, so a false flag would survive
        pin <= 1'b1;
        tick(1);
        `CHK(global_irq_enable, 1'b0)
        tick(0);
        `CHK(global_irq_enable, 1'b1)
        rd(ADDR_ICF, x, r);
        `CHK(x, 8'h80)
        // pin flag pending with its enable clear: no take, so the enable survives
        wr(ADDR_ICF, 8'h82, r);
        repeat (6) @(posedge mclk);
        `CHK(global_irq_enable, 1'b1)
        $display("enable test done");
        wr(ADDR_ICF, 8'h90, r);
        tick(2);
        `CHK(halted, 1'b1)
        pin <= 1'b0;
        `WAITF(wake)
        `WAITF(vload)
        `CHK(vaddr, IRQ_VECTOR)
        rd(ADDR_ICF, x, r);
        `CHK(x[1], 1'b1)
        $display("wake test done");
        wr(ADDR_ICF, 8'h80, r);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        `CHK(global_irq_enable, 1'b0)
        rd(ADDR_ICF, x, r);
        `CHK(x, ICF_RESET)
        $display("second reset done");
        summarize();
    end
endmodule // tb_irq_wake_controller
